// ===== hw/wdt_cfg_pkg.sv
// Constants, types and helper functions for the watchdog configuration block.
// Overview of operation
// - Mode 11 keeps the watchdog running whatever software enable holds.
// - Mode 10 runs the watchdog only while the software enable bit is set.
// - Mode 01 runs the watchdog only while awake, ignoring software enable.
// - Mode 00 keeps the watchdog off and ignores software enable.
// - Bit 6 set selects standard operation, clear selects windowed mode.
// - A clear while the watchdog is off never raises a reset request.
// - Bit 4 set divides the input clock by 128, clear divides it by 32.
// - The postscale ratio is two to the power of the 4-bit field.
package wdt_cfg_pkg;

    // ****************************************************************
    // Register map, byte addresses and field positions
    // ****************************************************************
    localparam logic [3:0] CFG_ADDR    = 4'h0;
    localparam logic [3:0] CTRL_ADDR   = 4'h4;
    localparam logic [3:0] STAT_ADDR   = 4'h8;
    localparam logic [3:0] COUNT_ADDR  = 4'hC;
    localparam logic [7:0] CFG_RESET   = 8'hDF;
    localparam int EN_HI_BIT   = 7;
    localparam int WINDOW_DISABLE_BIT  = 6;
    localparam int EN_LO_BIT   = 5;
    localparam int PSA_BIT     = 4;
    localparam int SWEN_BIT    = 5;
    localparam int CLEAR_BIT   = 0;
    localparam int ST_RUN_BIT  = 0;
    localparam int ST_TMO_BIT  = 1;
    localparam int ST_WIN_BIT  = 2;
    localparam int ST_WMODE_BIT = 3;

    // ****************************************************************
    // Enable modes and divider constants
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_ACTIVE = 2'b01,
        MODE_SW     = 2'b10,
        MODE_ON     = 2'b11
    } en_mode_t;

    localparam logic [6:0] PRE_LAST_128 = 7'h7F;
    localparam logic [6:0] PRE_LAST_32  = 7'h1F;
    localparam int POST_W = 15;

    // Register bus request travelling into the block.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    // Last postscale count for a given select code.
    function automatic logic [POST_W-1:0] post_last(input logic [3:0] ps);
        logic [15:0] ratio;
        ratio = 16'h0001 << ps;
        post_last = POST_W'(ratio - 16'h0001);
    endfunction

    // First postscale count at which a windowed clear is accepted.
    function automatic logic [POST_W-1:0] win_start(input logic [3:0] ps);
        logic [15:0] ratio;
        ratio = 16'h0001 << ps;
        if (ps < 4'h2) begin
            win_start = '0;
        end else begin
            win_start = POST_W'(ratio - (ratio >> 2));
        end
    endfunction

endpackage

// ===== hw/wdt_cfg_top.sv
// Watchdog timer with configuration byte decode and register port.
`timescale 1ns/1ns
module wdt_cfg_top #(
    parameter int ADDR_W = 4
) (
    // Clock and reset.
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    // Register port.
    input  wire wdt_cfg_pkg::bus_req_t BUS,
    output logic [7:0]                 RDATA,
    // Power state of the core.
    input  wire logic                  SLEEP,
    // Watchdog results.
    output logic                       RESET_REQ,
    output logic                       RUNNING
);
    import wdt_cfg_pkg::*;

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    if (ADDR_W != 4) begin : g_bad_addr
        $error("wdt_cfg_top supports only a 4-bit address");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]        cfg;
        logic              sw_en;
        logic [6:0]        pre_cnt;
        logic [POST_W-1:0] post_cnt;
        logic              tmo_flag;
        logic              win_flag;
        logic [7:0]        rdata;
        logic              rst_req;
        logic              running;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    en_mode_t          mode;
    logic              enabled;
    logic              windowed;
    logic [6:0]        pre_last_v;
    logic [POST_W-1:0] post_last_v;
    logic              clear_cmd;
    logic              expire;
    logic              win_viol;

    // Decode of the configuration byte into the running settings.
    always_comb begin
        mode = en_mode_t'({state_ff.cfg[EN_HI_BIT],
                           state_ff.cfg[EN_LO_BIT]});
        case (mode)
            MODE_ON:     enabled = 1'b1;
            MODE_SW:     enabled = state_ff.sw_en;
            MODE_ACTIVE: enabled = !SLEEP;
            MODE_OFF:    enabled = 1'b0;
            default:     enabled = 1'b0;
        endcase
        windowed = !state_ff.cfg[WINDOW_DISABLE_BIT];
        pre_last_v = state_ff.cfg[PSA_BIT] ? PRE_LAST_128
                                           : PRE_LAST_32;
        post_last_v = post_last(state_ff.cfg[3:0]);
    end

    // Clear command, expiry and early windowed clear detection.
    always_comb begin
        clear_cmd = BUS.wr && (BUS.addr == CTRL_ADDR)
                    && BUS.wdata[CLEAR_BIT];
        expire = enabled && !clear_cmd
                 && (state_ff.pre_cnt == pre_last_v)
                 && (state_ff.post_cnt == post_last_v);
        win_viol = enabled && windowed && clear_cmd
                   && (state_ff.post_cnt
                       < win_start(state_ff.cfg[3:0]));
    end

    // Next state: registers, counters, flags and read data.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rst_req = 1'b0;
        nxt_state.rdata = 8'h00;
        nxt_state.running = enabled;

        // Software writes.
        if (BUS.wr) begin
            case (BUS.addr)
                CFG_ADDR:  nxt_state.cfg = BUS.wdata;
                CTRL_ADDR: nxt_state.sw_en = BUS.wdata[SWEN_BIT];
                STAT_ADDR: begin
                    if (BUS.wdata[ST_TMO_BIT]) begin
                        nxt_state.tmo_flag = 1'b0;
                    end
                    if (BUS.wdata[ST_WIN_BIT]) begin
                        nxt_state.win_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Counting, restart and reset requests; hardware sets win over clears.
        if (!enabled || clear_cmd || expire) begin
            nxt_state.pre_cnt = '0;
            nxt_state.post_cnt = '0;
        end else if (state_ff.pre_cnt == pre_last_v) begin
            nxt_state.pre_cnt = '0;
            nxt_state.post_cnt = state_ff.post_cnt + 1'b1;
        end else begin
            nxt_state.pre_cnt = state_ff.pre_cnt + 1'b1;
        end
        if (expire) begin
            nxt_state.rst_req = 1'b1;
            nxt_state.tmo_flag = 1'b1;
        end
        if (win_viol) begin
            nxt_state.rst_req = 1'b1;
            nxt_state.win_flag = 1'b1;
        end

        // Read data, valid in the cycle after the strobe.
        if (BUS.rd) begin
            case (BUS.addr)
                CFG_ADDR: nxt_state.rdata = state_ff.cfg;
                CTRL_ADDR: begin
                    nxt_state.rdata[SWEN_BIT] = state_ff.sw_en;
                end
                STAT_ADDR: begin
                    nxt_state.rdata[ST_RUN_BIT] = enabled;
                    nxt_state.rdata[ST_TMO_BIT] = state_ff.tmo_flag;
                    nxt_state.rdata[ST_WIN_BIT] = state_ff.win_flag;
                    nxt_state.rdata[ST_WMODE_BIT] = windowed;
                end
                COUNT_ADDR: nxt_state.rdata = state_ff.post_cnt[7:0];
                default: nxt_state.rdata = 8'h00;
            endcase
        end
    end

    // State register.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_ff <= '0;
            state_ff.cfg <= CFG_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register.
    assign RDATA = state_ff.rdata;
    assign RESET_REQ = state_ff.rst_req;
    assign RUNNING = state_ff.running;

endmodule

// ===== dv/wdt_cfg_properties.sv
// Port checker for the watchdog configuration block.
`timescale 1ns/1ns
module wdt_cfg_properties (
    // Watched ports.
    input wire logic                  MCLK,
    input wire logic                  RST,
    input wire wdt_cfg_pkg::bus_req_t BUS,
    input wire logic [7:0]            RDATA,
    input wire logic                  SLEEP,
    input wire logic                  RESET_REQ,
    input wire logic                  RUNNING
);
    import wdt_cfg_pkg::*;
    logic [7:0]  cfg_ff;
    logic        sw_ff;
    logic [22:0] gap_ff;
    logic        en_c;
    logic [22:0] per_c;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Shadow settings and cycles since the last quiet expiry.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cfg_ff <= CFG_RESET;
            sw_ff <= 1'b0;
            gap_ff <= '0;
        end else begin
            if (BUS.wr && BUS.addr == CFG_ADDR) cfg_ff <= BUS.wdata;
            if (BUS.wr && BUS.addr == CTRL_ADDR) sw_ff <= BUS.wdata[SWEN_BIT];
            if (BUS.wr || !RUNNING) gap_ff <= '0;
            else if (RESET_REQ) gap_ff <= 23'h1;
            else if (gap_ff != '0) gap_ff <= gap_ff + 23'h1;
        end
    end
    // Expected enable and timeout period from the shadow byte.
    assign en_c = cfg_ff[7] ? (cfg_ff[5] | sw_ff) : (cfg_ff[5] & !SLEEP);
    assign per_c = (cfg_ff[PSA_BIT] ? 23'h80 : 23'h20) << cfg_ff[3:0];
    sequence s_clear;
        BUS.wr && BUS.addr == CTRL_ADDR && BUS.wdata[CLEAR_BIT];
    endsequence
    chk_run_decode: assert property (RUNNING == $past(en_c))
        else $error("running level does not follow mode");
    chk_rdata_idle: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    chk_cfg_read: assert property ($past(BUS.rd) && $past(BUS.addr) == CFG_ADDR |-> RDATA == $past(cfg_ff))
        else $error("config byte read back wrong");
    chk_req_pulse: assert property (RESET_REQ |=> !RESET_REQ || $past(BUS.wr))
        else $error("reset request longer than a pulse");
    chk_off_quiet: assert property (!RUNNING ##1 !RUNNING |-> !RESET_REQ)
        else $error("reset request while disabled");
    chk_expiry_time: assert property (RESET_REQ && gap_ff != '0 |-> gap_ff == per_c)
        else $error("timeout period wrong");
    chk_clear_restart: assert property (s_clear ##0 cfg_ff[WINDOW_DISABLE_BIT] |=> !RESET_REQ [*8])
        else $error("clear did not restart count");
    chk_window_early: assert property (s_clear ##0 (!cfg_ff[WINDOW_DISABLE_BIT] && cfg_ff[3:0] >= 4'h2 && RUNNING && gap_ff != '0 && gap_ff < 23'h20) |=> RESET_REQ)
        else $error("early windowed clear not punished");
endmodule
bind wdt_cfg_top wdt_cfg_properties wdt_cfg_properties_inst (.MCLK(MCLK),
    .RST(RST), .BUS(BUS), .RDATA(RDATA), .SLEEP(SLEEP),
    .RESET_REQ(RESET_REQ), .RUNNING(RUNNING));

// ===== dv/testbench.sv
// Self-checking bench for the watchdog configuration block.
`timescale 1ns/1ns
module testbench;
    import wdt_cfg_pkg::*;
    logic       MCLK = 1'b0;
    logic       RST = 1'b1;
    bus_req_t   BUS = '0;
    logic       SLEEP = 1'b0;
    logic [7:0] RDATA;
    logic       RESET_REQ;
    logic       RUNNING;
    logic [7:0] v;
    logic [7:0] c;
    int         err_count = 0;
    int         checked = 0;
    int         cycles = 0;
    int         pulses = 0;
    int         p0;
    int         n;
    wdt_cfg_top wdt_cfg_top_inst (.MCLK(MCLK), .RST(RST), .BUS(BUS),
        .RDATA(RDATA), .SLEEP(SLEEP), .RESET_REQ(RESET_REQ), .RUNNING(RUNNING));
    // Clock, request counter and cycle ceiling.
    always #25 MCLK = ~MCLK;
    // Reset requests are counted on the falling edge, where they are settled.
    always @(negedge MCLK) begin
        if (RESET_REQ === 1'b1) pulses++;
    end
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge MCLK);
        BUS <= '0;
        @(posedge MCLK);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge MCLK);
        BUS <= '0;
        @(posedge MCLK);
        d = RDATA;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Counts edges until a reset request shows, up to a limit.
    task automatic wait_req(input int lim, output int k);
        k = 0;
        do begin
            @(posedge MCLK);
            k++;
        end while (RESET_REQ !== 1'b1 && k < lim);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence: reset value, modes, periods, clears and window.
    initial begin
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        rd(CFG_ADDR, v);
        cmp(16'(v), 16'(CFG_RESET));
        rd(4'h2, v);
        cmp(16'(v), 16'h0000);
        for (int k = 0; k < 16; k++) begin
            wr(CFG_ADDR, {k[3], 1'b1, k[2], 5'h1F});
            wr(CTRL_ADDR, {2'h0, k[1], 5'h00});
            SLEEP <= k[0];
            repeat (3) @(posedge MCLK);
            cmp(16'(RUNNING), 16'(k[3] ? k[2] | k[1] : k[2] & ~k[0]));
        end
        SLEEP <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 8'hE0 : (i == 1) ? 8'hE2 : 8'hF3;
            wr(CFG_ADDR, c);
            wait_req(1100, n);
            wait_req(1100, n);
            cmp(16'(n), (c[PSA_BIT] ? 16'h80 : 16'h20) << c[3:0]);
        end
        wr(CFG_ADDR, 8'hE0);
        wait_req(100, n);
        p0 = pulses;
        repeat (3) begin
            repeat (20) @(posedge MCLK);
            wr(CTRL_ADDR, 8'h01);
        end
        cmp(16'(pulses - p0), 16'h0000);
        wr(CFG_ADDR, 8'hA2);
        wait_req(300, n);
        p0 = pulses;
        wr(CTRL_ADDR, 8'h01);
        repeat (3) @(posedge MCLK);
        cmp(16'(pulses - p0), 16'h0001);
        rd(STAT_ADDR, v);
        cmp(16'(v), 16'h000F);
        wr(CFG_ADDR, 8'h00);
        p0 = pulses;
        wr(CTRL_ADDR, 8'h01);
        repeat (40) @(posedge MCLK);
        cmp(16'(pulses - p0), 16'h0000);
        tally_and_finish();
    end
endmodule
